// [hw/bms_core.sv]
// buck converter mode control, status and power-good with apb registers
// assumes sense comparators and the switching clock are asynchronous
// to pclk; apb master is on pclk
`timescale 1ns/10ps

module bms_core
#(
	parameter int MIN_OFF = bms_pkg::MIN_OFF_CYC,
	parameter int REFRESH_N = bms_pkg::REFRESH_PERIOD,
	parameter int SS_N = bms_pkg::SPSP_PERIODS
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sw_clk,
	input wire bms_pkg::bms_sense_t sense,
	output logic hs_gate_on,
	output logic [$clog2(SS_N)-2:0] dither_code,
	output logic const_cur_loop_en,
	output logic constant_current_mode,
	output logic [bms_pkg::ILIM_REF_W-1:0] current_regulation_target,
	output logic [bms_pkg::VTGT_W-1:0] servo_vref_code,
	output logic host_irq,
	output logic power_good_output_out,
	output logic power_good_output_oe
);
	import bms_pkg::*;

	localparam int RC_W = $clog2(REFRESH_N);
	localparam int SS_W = $clog2(SS_N);
	localparam int OFF_W = $clog2(MIN_OFF + 1);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ==========================================================
	// functions
	function automatic logic [ILIM_REF_W-1:0] ilim_ref_na(
		input logic [ILIM_W-1:0] c);
		ilim_ref_na = ILIM_UNIT_NA * ({9'h000, c} + 17'h00001);
	endfunction

	function automatic logic [PGD_CW-1:0] pgd_cycles(input logic [1:0] s);
		case (s)
			2'h0: pgd_cycles = PGD_CW'(PGD0_CYC);
			2'h1: pgd_cycles = PGD_CW'(PGD1_CYC);
			2'h2: pgd_cycles = PGD_CW'(PGD2_CYC);
			default: pgd_cycles = PGD_CW'(PGD3_CYC);
		endcase
	endfunction

	// ==========================================================
	// input synchronisers
	bms_sense_t sense_meta_r;
	bms_sense_t sense_r;
	logic sw_meta_r;
	logic sw_sync_r;
	logic sw_prev_r;
	logic sw_rise;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sense_meta_r <= '0;
			sense_r <= '0;
			sw_meta_r <= 1'b0;
			sw_sync_r <= 1'b0;
			sw_prev_r <= 1'b0;
		end
		else
		begin
			sense_meta_r <= sense;
			sense_r <= sense_meta_r;
			sw_meta_r <= sw_clk;
			sw_sync_r <= sw_meta_r;
			sw_prev_r <= sw_sync_r;
		end
	end

	// one pclk pulse per switching period
	assign sw_rise = sw_sync_r & ~sw_prev_r;

	// ==========================================================
	// apb decode
	logic [5:0] idx;
	logic setup_ph;
	logic wr_acc;
	logic mapped;
	logic flag_clr;

	assign idx = paddr[7:2];
	assign setup_ph = psel & ~penable;
	assign wr_acc = psel & penable & pwrite;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign flag_clr = wr_acc & (idx == IDX_FLAG) & pwdata[FLAG_XFER_BIT];

	always_comb
	begin
		case (idx)
			IDX_FLAG, IDX_STAT, IDX_EN, IDX_PGD,
			IDX_MODE, IDX_ILIM, IDX_VTGT: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// ==========================================================
	// software registers
	logic en_bit_r;
	logic [1:0] pgd_sel_r;
	logic fd_en_r;
	logic ss_en_r;
	logic ccur_en_r;
	logic [ILIM_W-1:0] ilim_r;
	logic [VTGT_W-1:0] vtgt_r;

	// writes land at any time, so targets change on the fly
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_bit_r <= EN_RST;
			pgd_sel_r <= PGD_RST;
			fd_en_r <= MODE_BIT_RST;
			ss_en_r <= MODE_BIT_RST;
			ccur_en_r <= MODE_BIT_RST;
			ilim_r <= ILIM_RST;
			vtgt_r <= VTGT_RST;
		end
		else if (wr_acc)
		begin
			case (idx)
				IDX_EN: en_bit_r <= pwdata[EN_BIT];
				IDX_PGD: pgd_sel_r <= pwdata[PGD_LSB+:2];
				IDX_MODE:
				begin
					fd_en_r <= pwdata[MODE_FDUTY_BIT];
					ss_en_r <= pwdata[MODE_SS_BIT];
					ccur_en_r <= pwdata[MODE_CCUR_BIT];
				end
				IDX_ILIM: ilim_r <= pwdata[ILIM_W-1:0];
				IDX_VTGT: vtgt_r <= pwdata[VTGT_W-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// enable and servo references
	logic internal_enable;
	logic [ILIM_W-1:0] ilim_code;
	logic vbusy;
	logic ibusy;

	assign internal_enable = sense_r.en_pin | en_bit_r;

	bms_servo #(.W(VTGT_W)) u_vservo
	(
		.clk(pclk),
		.rst_n(presetn),
		.hold(~internal_enable),
		.step(sw_rise),
		.target(vtgt_r),
		.code(servo_vref_code),
		.busy(vbusy)
	);

	bms_servo #(.W(ILIM_W)) u_iservo
	(
		.clk(pclk),
		.rst_n(presetn),
		.hold(~internal_enable),
		.step(sw_rise),
		.target(ilim_r),
		.code(ilim_code),
		.busy(ibusy)
	);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			current_regulation_target <= '0;
		else
			current_regulation_target <= ilim_ref_na(ilim_code);
	end

	// ==========================================================
	// high-side switch, minimum off and bootstrap refresh
	logic [RC_W-1:0] refresh_cnt_r;
	logic [OFF_W-1:0] off_cnt_r;
	logic refresh_due;
	logic force_off;
	logic full_duty_r;

	assign refresh_due = (refresh_cnt_r == RC_W'(REFRESH_N - 1));
	assign force_off = sw_rise & (~fd_en_r | refresh_due);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			refresh_cnt_r <= '0;
		else if (!fd_en_r)
			refresh_cnt_r <= '0;
		else if (sw_rise)
			refresh_cnt_r <= refresh_due ? '0 : refresh_cnt_r + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			off_cnt_r <= '0;
		else if (force_off)
			off_cnt_r <= OFF_W'(MIN_OFF - 1);
		else if (off_cnt_r != '0)
			off_cnt_r <= off_cnt_r - 1'b1;
	end

	// demand passes straight through once no off window runs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hs_gate_on <= 1'b0;
		else
			hs_gate_on <= sense_r.pwm_demand & ~force_off
				& (off_cnt_r == '0);
	end

	// status: high side carried on through a period boundary
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			full_duty_r <= 1'b0;
		else if (!fd_en_r || !sense_r.pwm_demand)
			full_duty_r <= 1'b0;
		else if (sw_rise && hs_gate_on)
			full_duty_r <= 1'b1;
	end

	// ==========================================================
	// spread spectrum triangle
	logic [SS_W-1:0] ss_cnt_r;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ss_cnt_r <= '0;
		else if (!ss_en_r)
			ss_cnt_r <= '0;
		else if (sw_rise)
			ss_cnt_r <= (ss_cnt_r == SS_W'(SS_N - 1)) ? '0
				: ss_cnt_r + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dither_code <= '0;
		else if (!ss_en_r)
			dither_code <= '0;
		else
			dither_code <= ss_cnt_r[SS_W-1] ? ~ss_cnt_r[SS_W-2:0]
				: ss_cnt_r[SS_W-2:0];
	end

	// ==========================================================
	// constant current arming, mode and transition flag
	logic armed_nxt;
	logic ccur_nxt;
	logic in_win_r;
	logic xfer_flag_r;

	always_comb
	begin
		if (!ccur_en_r)
			armed_nxt = 1'b0;
		else if (sense_r.fbk_above_rise)
			armed_nxt = 1'b1;
		else if (sense_r.fbk_below_fall)
			armed_nxt = 1'b0;
		else
			armed_nxt = const_cur_loop_en;
	end

	assign ccur_nxt = armed_nxt & sense_r.cs_at_limit;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			const_cur_loop_en <= 1'b0;
			constant_current_mode <= 1'b0;
			in_win_r <= 1'b0;
		end
		else
		begin
			const_cur_loop_en <= armed_nxt;
			constant_current_mode <= ccur_nxt;
			in_win_r <= sense_r.vo_above_low & sense_r.vo_below_high;
		end
	end

	// a change in the clear cycle still sets the flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			xfer_flag_r <= 1'b0;
		else if (ccur_nxt != constant_current_mode)
			xfer_flag_r <= 1'b1;
		else if (flag_clr)
			xfer_flag_r <= 1'b0;
	end

	assign host_irq = xfer_flag_r;

	// ==========================================================
	// register read
	logic [31:0] rd_word;

	always_comb
	begin
		rd_word = '0;
		case (idx)
			IDX_FLAG: rd_word[FLAG_XFER_BIT] = xfer_flag_r;
			IDX_STAT:
			begin
				rd_word[STAT_CCUR_BIT] = constant_current_mode;
				rd_word[STAT_FDUTY_BIT] = full_duty_r;
				rd_word[STAT_WIN_BIT] = in_win_r;
			end
			IDX_EN: rd_word[EN_BIT] = en_bit_r;
			IDX_PGD: rd_word[PGD_LSB+:2] = pgd_sel_r;
			IDX_MODE:
			begin
				rd_word[MODE_FDUTY_BIT] = fd_en_r;
				rd_word[MODE_SS_BIT] = ss_en_r;
				rd_word[MODE_CCUR_BIT] = ccur_en_r;
			end
			IDX_ILIM: rd_word[ILIM_W-1:0] = ilim_r;
			IDX_VTGT: rd_word[VTGT_W-1:0] = vtgt_r;
			default: rd_word = '0;
		endcase
	end

	// captured in setup so the access phase needs no wait state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (setup_ph && !pwrite)
			prdata <= rd_word;
	end

	// ==========================================================
	// power-good with delay
	bms_pgst_t pwrgd_st_r;
	bms_pgst_t pwrgd_st_nxt;
	logic [PGD_CW-1:0] pgd_cnt_r;
	logic pgd_done;
	logic force_low;
	logic good_int;
	logic pwrgd_r;

	// servo or disable drop the output at once, not after the delay
	assign force_low = ~internal_enable | vbusy | ibusy;
	assign good_int = in_win_r | constant_current_mode;
	// at or past the end: a delay code shortened mid-count still ends
	assign pgd_done = (pgd_cnt_r >= pgd_cycles(pgd_sel_r) - 1'b1);

	always_comb
	begin
		case (pwrgd_st_r)
			PGS_OFF:
			begin
				if (!force_low && good_int)
					pwrgd_st_nxt = PGS_RISE;
				else
					pwrgd_st_nxt = PGS_OFF;
			end
			PGS_RISE:
			begin
				if (force_low || !good_int)
					pwrgd_st_nxt = PGS_OFF;
				else
					pwrgd_st_nxt = pgd_done ? PGS_ON : PGS_RISE;
			end
			PGS_ON:
			begin
				if (force_low)
					pwrgd_st_nxt = PGS_OFF;
				else
					pwrgd_st_nxt = good_int ? PGS_ON : PGS_FALL;
			end
			PGS_FALL:
			begin
				if (force_low)
					pwrgd_st_nxt = PGS_OFF;
				else if (good_int)
					pwrgd_st_nxt = PGS_ON;
				else
					pwrgd_st_nxt = pgd_done ? PGS_OFF : PGS_FALL;
			end
			default: pwrgd_st_nxt = PGS_OFF;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pwrgd_st_r <= PGS_OFF;
			pgd_cnt_r <= '0;
			pwrgd_r <= 1'b0;
		end
		else
		begin
			pwrgd_st_r <= pwrgd_st_nxt;
			pgd_cnt_r <= (pwrgd_st_nxt != pwrgd_st_r) ? '0
				: pgd_cnt_r + 1'b1;
			pwrgd_r <= (pwrgd_st_nxt == PGS_ON)
				|| (pwrgd_st_nxt == PGS_FALL);
		end
	end

	// open drain: drive low unless good
	assign power_good_output_out = 1'b0;
	assign power_good_output_oe = ~pwrgd_r;

	// ==========================================================
	// checks
	property p_min_off;
		(sw_rise && !fd_en_r) |=> !hs_gate_on;
	endproperty
	a_min_off: assert property (p_min_off)
		else $error("minimum off not forced");

	property p_fd_hold;
		(fd_en_r && !sw_rise && off_cnt_r == '0 && sense_r.pwm_demand)
			|=> hs_gate_on;
	endproperty
	a_fd_hold: assert property (p_fd_hold)
		else $error("high side dropped in full duty");

	property p_refresh;
		(sw_rise && fd_en_r && refresh_due) |=> !hs_gate_on;
	endproperty
	a_refresh: assert property (p_refresh)
		else $error("bootstrap refresh missing");

	property p_fd_only_enabled;
		!fd_en_r |=> !full_duty_r;
	endproperty
	a_fd_only_enabled: assert property (p_fd_only_enabled)
		else $error("full duty status without enable");

	property p_fd_status;
		(fd_en_r && sw_rise && hs_gate_on && sense_r.pwm_demand
			&& $past(fd_en_r)) |=> full_duty_r;
	endproperty
	a_fd_status: assert property (p_fd_status)
		else $error("full duty status not set");

	property p_ccur_off;
		!ccur_en_r |=> (!constant_current_mode && !const_cur_loop_en);
	endproperty
	a_ccur_off: assert property (p_ccur_off)
		else $error("constant current while disabled");

	property p_arm;
		(ccur_en_r && sense_r.fbk_above_rise) |=> const_cur_loop_en;
	endproperty
	a_arm: assert property (p_arm)
		else $error("constant current not armed");

	property p_xfer;
		$changed(constant_current_mode) |-> (xfer_flag_r && host_irq);
	endproperty
	a_xfer: assert property (p_xfer)
		else $error("transition flag not set");

	property p_flag_sticky;
		(xfer_flag_r && !flag_clr) |=> xfer_flag_r;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("transition flag lost");

	property p_pg_servo;
		(vbusy || ibusy) |=> power_good_output_oe;
	endproperty
	a_pg_servo: assert property (p_pg_servo)
		else $error("power good during servo ramp");

	property p_pg_disabled;
		!internal_enable |=> !pwrgd_r;
	endproperty
	a_pg_disabled: assert property (p_pg_disabled)
		else $error("power good while disabled");

endmodule

// [shared/bms_pkg.sv]
// constants, register map and types for the buck mode and status block
// assumes a 25 MHz pclk and apb byte addresses of four times the index
package bms_pkg;

	// ==========================================================
	// timing
	localparam int CLK_MHZ = 25;
	localparam int MIN_OFF_NS = 80;
	// least time, rounded up to whole cycles
	localparam int MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;
	localparam int REFRESH_PERIOD = 8;
	localparam int SPSP_PERIODS = 16;
	localparam int PGD0_US = 1;
	localparam int PGD1_US = 10;
	localparam int PGD2_US = 50;
	localparam int PGD3_US = 100;
	localparam int PGD0_CYC = PGD0_US * CLK_MHZ;
	localparam int PGD1_CYC = PGD1_US * CLK_MHZ;
	localparam int PGD2_CYC = PGD2_US * CLK_MHZ;
	localparam int PGD3_CYC = PGD3_US * CLK_MHZ;
	localparam int PGD_CW = 12;

	// ==========================================================
	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_FLAG = 6'h01;
	localparam logic [5:0] IDX_STAT = 6'h03;
	localparam logic [5:0] IDX_EN = 6'h05;
	localparam logic [5:0] IDX_PGD = 6'h08;
	localparam logic [5:0] IDX_MODE = 6'h0B;
	localparam logic [5:0] IDX_ILIM = 6'h0C;
	localparam logic [5:0] IDX_VTGT = 6'h10;

	// ==========================================================
	// field positions
	localparam int FLAG_XFER_BIT = 7;
	localparam int STAT_CCUR_BIT = 4;
	localparam int STAT_FDUTY_BIT = 3;
	localparam int STAT_WIN_BIT = 2;
	localparam int EN_BIT = 0;
	localparam int PGD_LSB = 6;
	localparam int MODE_FDUTY_BIT = 7;
	localparam int MODE_SS_BIT = 6;
	localparam int MODE_CCUR_BIT = 4;

	// ==========================================================
	// widths and reset values
	localparam int VTGT_W = 11;
	localparam int ILIM_W = 8;
	localparam int ILIM_REF_W = 17;
	localparam logic [ILIM_REF_W-1:0] ILIM_UNIT_NA = 17'h00187;
	localparam logic EN_RST = 1'b0;
	localparam logic [1:0] PGD_RST = 2'h0;
	localparam logic MODE_BIT_RST = 1'b0;
	localparam logic [ILIM_W-1:0] ILIM_RST = 8'h00;
	localparam logic [VTGT_W-1:0] VTGT_RST = 11'h000;

	// ==========================================================
	// types
	typedef struct packed {
		logic en_pin;
		logic pwm_demand;
		logic fbk_above_rise;
		logic fbk_below_fall;
		logic cs_at_limit;
		logic vo_above_low;
		logic vo_below_high;
	} bms_sense_t;

	typedef enum logic [1:0] {
		PGS_OFF = 2'b00,
		PGS_RISE = 2'b01,
		PGS_ON = 2'b10,
		PGS_FALL = 2'b11
	} bms_pgst_t;

endpackage

// [hw/bms_servo.sv]
// servo reference up/down counter stepping once per switching cycle
// assumes hold and step come from logic on the same clock
`timescale 1ns/10ps

module bms_servo
#(
	parameter int W = 11
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hold,
	input wire logic step,
	input wire logic [W-1:0] target,
	output logic [W-1:0] code,
	output logic busy
);
	import bms_pkg::*;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// counter
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			code <= '0;
		else if (hold)
			code <= '0;
		else if (step && code < target)
			code <= code + 1'b1;
		else if (step && code > target)
			code <= code - 1'b1;
	end

	assign busy = (code != target);

	// ==========================================================
	// checks
	property p_servo_hold;
		hold |=> (code == '0);
	endproperty
	a_servo_hold: assert property (p_servo_hold)
		else $error("servo code not held at zero");

	property p_servo_up;
		(!hold && step && code < target) |=> (code == $past(code) + 1'b1);
	endproperty
	a_servo_up: assert property (p_servo_up)
		else $error("servo did not step toward target");

endmodule

// [testbench/bms_plant.sv]
// plant model: switching clock and comparator levels seen by the block
// assumes the bench sets the wanted levels on pclk edges
`timescale 1ns/10ps

module bms_plant
(
	input wire bms_pkg::bms_sense_t want,
	output bms_pkg::bms_sense_t sense,
	output logic sw_clk
);
	import bms_pkg::*;

	// ==========================================================
	// switching clock
	// fixed-frequency converter runs free, phase unrelated to pclk
	initial
	begin
		sw_clk = 1'b0;
		#7;
		forever #160 sw_clk = ~sw_clk;
	end

	// ==========================================================
	// comparators
	// ideal levels, no chatter near the thresholds
	assign sense = want;
endmodule

// [testbench/tb.sv]
// self-checking bench for the buck mode and status block over apb
// assumes the plant model supplies sw_clk and the sense levels
`timescale 1ns/10ps

module tb;
	import bms_pkg::*;

	// ==========================================================
	// signals
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic sw_clk, hs_gate_on, ccl_en, ccur_mode, irq, pwrgd_out, pwrgd_oe;
	logic pwrgd_pin;
	logic [2:0] dith, d0;
	logic [ILIM_REF_W-1:0] itgt;
	logic [VTGT_W-1:0] vcode;
	bms_sense_t want, sense;
	int n_errors, n_tests, c;
	logic [5:0] ix_tab [7] = '{IDX_FLAG, IDX_STAT, IDX_EN, IDX_PGD,
		IDX_MODE, IDX_ILIM, IDX_VTGT};
	int dly [4] = '{PGD0_CYC, PGD1_CYC, PGD2_CYC, PGD3_CYC};

	// open-drain pin with pull-up
	assign pwrgd_pin = pwrgd_oe ? pwrgd_out : 1'b1;

	bms_plant i_bms_plant (.want(want), .sense(sense), .sw_clk(sw_clk));

	bms_core i_bms_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sw_clk(sw_clk), .sense(sense),
		.hs_gate_on(hs_gate_on), .dither_code(dith),
		.const_cur_loop_en(ccl_en), .constant_current_mode(ccur_mode),
		.current_regulation_target(itgt), .servo_vref_code(vcode),
		.host_irq(irq), .power_good_output_out(pwrgd_out),
		.power_good_output_oe(pwrgd_oe));

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	// ==========================================================
	// helpers
	task automatic complete_run();
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// values are read before the edge's own updates land
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic xfer(input logic w, input logic [5:0] ix,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {ix, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do
		begin
			@(posedge pclk);
			t++;
		end
		while (pready !== 1'b1 && t < 20);
		if (pready !== 1'b1)
		begin
			n_errors++;
			complete_run();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] ix, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'b1, ix, d, q, e);
	endtask

	task automatic rchk(input string nm, input logic [5:0] ix,
		input logic [31:0] exp);
		logic e;
		xfer(1'b0, ix, 32'h0, rd, e);
		chk(nm, rd, exp);
	endtask

	task automatic cnt_low(input int n, output int k);
		k = 0;
		repeat (n)
		begin
			tick(1);
			if (hs_gate_on === 1'b0)
				k++;
		end
	endtask

	// ==========================================================
	// hang guard
	initial
	begin
		tick(60000);
		n_errors++;
		complete_run();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		want = '0;
		n_errors = 0;
		n_tests = 0;
		tick(3);
		presetn <= 1'b1;
		chk("pwrgd_rst", pwrgd_pin, 1'b0);
		chk("irq_rst", irq, 1'b0);
		foreach (ix_tab[k])
			rchk("rst_val", ix_tab[k], 32'h0);
		xfer(1'b1, 6'h3F, 32'hFFFF_FFFF, rd, err);
		chk("slverr_wr", err, 1'b1);
		xfer(1'b0, 6'h3F, 32'h0, rd, err);
		chk("slverr_rd", err, 1'b1);
		chk("unmapped_rd", rd, 32'h0);
		wr(IDX_MODE, 32'hFFFF_FFFF);
		rchk("mode_rw", IDX_MODE, 32'hD0);
		wr(IDX_PGD, 32'hFFFF_FFFF);
		rchk("pgd_rw", IDX_PGD, 32'hC0);
		wr(IDX_STAT, 32'hFF);
		wr(IDX_MODE, 32'h0);
		wr(IDX_PGD, 32'h0);
		rchk("stat_ro", IDX_STAT, 32'h0);
		// off windows: 64 cycles hold exactly 8 switching periods
		want.pwm_demand <= 1'b1;
		tick(20);
		cnt_low(64, c);
		chk("min_off", c, 8 * MIN_OFF_CYC);
		rchk("fd_off_stat", IDX_STAT, 32'h0);
		wr(IDX_MODE, 32'h80);
		tick(20);
		cnt_low(64, c);
		chk("refresh", c, MIN_OFF_CYC);
		rchk("fd_stat", IDX_STAT, 32'h08);
		want.pwm_demand <= 1'b0;
		wr(IDX_MODE, 32'h40);
		tick(40);
		d0 = dith;
		c = 0;
		repeat (128)
		begin
			tick(1);
			if (dith === 3'h7)
				c++;
		end
		chk("ss_repeat", dith, d0);
		chk("ss_peak", c > 0, 1'b1);
		wr(IDX_MODE, 32'h0);
		tick(4);
		chk("ss_off", dith, 3'h0);
		want.fbk_above_rise <= 1'b1;
		tick(8);
		chk("ccur_gate", ccl_en, 1'b0);
		wr(IDX_MODE, 32'h10);
		tick(4);
		chk("ccur_arm", ccl_en, 1'b1);
		want.fbk_above_rise <= 1'b0;
		want.cs_at_limit <= 1'b1;
		tick(6);
		chk("ccur_hold", ccl_en, 1'b1);
		chk("ccur_mode", ccur_mode, 1'b1);
		chk("ccur_irq", irq, 1'b1);
		rchk("ccur_stat", IDX_STAT, 32'h10);
		rchk("ccur_flag", IDX_FLAG, 32'h80);
		wr(IDX_FLAG, 32'h80);
		tick(2);
		chk("flag_clr", irq, 1'b0);
		want.cs_at_limit <= 1'b0;
		tick(6);
		chk("cvol_mode", ccur_mode, 1'b0);
		chk("cvol_irq", irq, 1'b1);
		wr(IDX_FLAG, 32'h80);
		want.fbk_below_fall <= 1'b1;
		tick(6);
		chk("ccur_disarm", ccl_en, 1'b0);
		want.fbk_below_fall <= 1'b0;
		wr(IDX_MODE, 32'h0);
		want.vo_above_low <= 1'b1;
		want.vo_below_high <= 1'b1;
		tick(6);
		rchk("win_stat", IDX_STAT, 32'h04);
		chk("pwrgd_dis", pwrgd_pin, 1'b0);
		chk("ilim_ref", itgt, 32'd391);
		wr(IDX_EN, 32'h1);
		tick(dly[0] - 2);
		chk("pwrgd_early", pwrgd_pin, 1'b0);
		tick(10);
		chk("pwrgd_on", pwrgd_pin, 1'b1);
		wr(IDX_ILIM, 32'hFF);
		tick(3);
		chk("pwrgd_iservo", pwrgd_pin, 1'b0);
		tick(2100);
		chk("ilim_max", itgt, 32'd391 * 32'd256);
		wr(IDX_VTGT, 32'hFFFF_FFFF);
		rchk("vtgt_rw", IDX_VTGT, 32'h7FF);
		tick(3);
		chk("pwrgd_vservo", pwrgd_pin, 1'b0);
		tick(16500);
		chk("vramp", vcode, 11'h7FF);
		tick(40);
		chk("pwrgd_back", pwrgd_pin, 1'b1);
		// leaving the window: both edges delayed by the chosen time
		for (int k = 0; k < 4; k++)
		begin
			wr(IDX_PGD, 32'(k) << 6);
			want.vo_below_high <= 1'b0;
			tick(dly[k] - 2);
			chk("pwrgd_hold", pwrgd_pin, 1'b1);
			tick(10);
			chk("pwrgd_fall", pwrgd_pin, 1'b0);
			want.vo_below_high <= 1'b1;
			tick(dly[k] - 2);
			chk("pwrgd_low", pwrgd_pin, 1'b0);
			tick(10);
			chk("pwrgd_rise", pwrgd_pin, 1'b1);
		end
		wr(IDX_EN, 32'h0);
		tick(3);
		chk("en_off", vcode, 11'h0);
		chk("pwrgd_off", pwrgd_pin, 1'b0);
		want.en_pin <= 1'b1;
		tick(20);
		chk("pin_en", vcode != 11'h0, 1'b1);
		complete_run();
	end
endmodule
